/* File: bench/tdr_bus_master.sv */
// Bus master model that drives the far side of the two-wire DAC code receiver.
// Assumes a pull-up on both lines and a free-running link clock that paces every bit.
`timescale 1ns/1ps
`default_nettype none

module tdr_bus_master (
  input wire logic link_clk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_drv
);
  // Low and high phases in link clock cycles; the bit period of 54 cycles stays under 400 kHz.
  localparam int T_LOW = 28;
  localparam int T_HIGH = 26;

  ////////////////////////////////////////////////////////////////////////////////
  // Both lines are released while no frame is running.
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge link_clk);
  endtask

  // Data falls while the clock is high, then the clock drops.
  task automatic start_cond();
    sda_drv = 1'b0;
    wait_clk(T_HIGH);
    scl = 1'b0;
    wait_clk(T_LOW / 2);
  endtask

  task automatic restart_cond();
    sda_drv = 1'b1;
    wait_clk(T_LOW / 2);
    scl = 1'b1;
    wait_clk(T_HIGH);
    start_cond();
  endtask

  // Data rises while the clock is high, and the bus is left idle.
  task automatic stop_cond();
    sda_drv = 1'b0;
    wait_clk(T_LOW / 2);
    scl = 1'b1;
    wait_clk(T_HIGH);
    sda_drv = 1'b1;
    wait_clk(T_LOW);
  endtask

  // Data moves only in the low phase, so the device sees it stable while high.
  task automatic clock_bit(input logic b, output logic r);
    sda_drv = b;
    wait_clk(T_LOW / 2);
    scl = 1'b1;
    wait_clk(T_HIGH / 2);
    r = sda_wire;
    wait_clk(T_HIGH / 2);
    scl = 1'b0;
    wait_clk(T_LOW / 2);
  endtask

  // Eight bits MSB first, then a released ninth clock for the answer.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic acked);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(tx[i], r);
      rx[i] = r;
    end
    clock_bit(1'b1, r);
    acked = ~r;
  endtask
endmodule

`default_nettype wire

/* File: bench/tdr_receiver_tb_top.sv */
// Self-checking testbench for the two-wire DAC code receiver.
// Assumes the bus master model drives the bus and both lines have pull-ups.
`timescale 1ns/1ps
`default_nettype none

module tdr_receiver_tb_top;
  localparam logic [7:0] MY_ADDR = tdr_pkg::ADDR_OPT_1;
  logic ref_clk;
  logic link_clk;
  logic reset;
  logic scl;
  logic sda_drv;
  logic sda_wire;
  logic sda_out;
  logic sda_oe;
  logic [5:0] dac_code;
  logic power_down;
  logic circuit_enable;
  logic output_live;
  logic [5:0] code_exp;
  int fails;
  int check_count;
  int live_cnt;

  ////////////////////////////////////////////////////////////////////////////////
  // Open-drain data wire: either party may pull it low.
  assign sda_wire = sda_drv & ~(sda_oe & ~sda_out);

  tdr_receiver #(.ADDR_OPTION(1)) u_dut (
    .ref_clk(ref_clk),
    .reset(reset),
    .scl_in(scl),
    .sda_in(sda_wire),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .dac_code(dac_code),
    .power_down(power_down),
    .circuit_enable(circuit_enable),
    .output_live(output_live)
  );

  tdr_bus_master u_master (
    .link_clk(link_clk),
    .sda_wire(sda_wire),
    .scl(scl),
    .sda_drv(sda_drv)
  );

  // Two unrelated clocks; the link clock is offset so no edges line up.
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  initial begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end

  // Cycles since the power-down flag last fell, counted on the falling edge where outputs have settled.
  always @(negedge ref_clk) begin
    if (power_down !== 1'b0) begin
      live_cnt <= 0;
    end else if (live_cnt < 4000) begin
      live_cnt <= live_cnt + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // One write-shaped frame; the code must not move before the STOP.
  task automatic frame(input logic [7:0] a, input logic [7:0] d, input logic exp_a, input logic restart);
    logic [7:0] rx;
    logic ack;
    u_master.start_cond();
    u_master.xfer(a, rx, ack);
    check({7'h0, ack}, {7'h0, exp_a});
    u_master.xfer(d, rx, ack);
    check({7'h0, ack}, {7'h0, exp_a});
    check({2'h0, dac_code}, {2'h0, code_exp});
    if (restart) begin
      u_master.restart_cond();
    end
    u_master.stop_cond();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    check({2'h0, dac_code}, 8'h00);
    check({6'h0, power_down, output_live}, 8'h01);
    $display("test_reset done");
  endtask

  task automatic test_write();
    logic [5:0] codes [4] = '{6'h3F, 6'h20, 6'h01, 6'h2A};
    for (int i = 0; i < 4; i++) begin
      frame(MY_ADDR, {codes[i], 2'b00}, 1'b1, 1'b0);
      code_exp = codes[i];
      check({1'b0, power_down, dac_code}, {2'h0, code_exp});
    end
    $display("test_write done");
  endtask

  // Address-only probes, both power bits, ended by STOP or by a restart.
  task automatic test_search();
    logic [7:0] rx;
    logic ack;
    for (int i = 0; i < 4; i++) begin
      u_master.start_cond();
      u_master.xfer(MY_ADDR | 8'(i[0]), rx, ack);
      check({7'h0, ack}, 8'h01);
      if (i[1]) begin
        u_master.restart_cond();
      end
      u_master.stop_cond();
      check({1'b0, power_down, dac_code}, {2'h0, code_exp});
    end
    $display("test_search done");
  endtask

  // Other presets, the general call and a ten-bit header are all ignored.
  task automatic test_mismatch();
    logic [7:0] bad [4] = '{tdr_pkg::ADDR_OPT_0, tdr_pkg::ADDR_OPT_3, 8'h00, 8'hF0};
    for (int i = 0; i < 4; i++) begin
      frame(bad[i], 8'hFC, 1'b0, 1'b0);
      check({1'b0, power_down, dac_code}, {2'h0, code_exp});
    end
    $display("test_mismatch done");
  endtask

  task automatic test_restart();
    frame(MY_ADDR, 8'h54, 1'b1, 1'b1);
    check({1'b0, power_down, dac_code}, {2'h0, code_exp});
    $display("test_restart done");
  endtask

  // Read-out enters shutdown; a later write wakes it after the fixed delay.
  task automatic test_shutdown();
    logic [7:0] rx;
    logic ack;
    int n;
    u_master.start_cond();
    u_master.xfer(MY_ADDR | 8'h01, rx, ack);
    check({7'h0, ack}, 8'h01);
    u_master.xfer(8'hFF, rx, ack);
    check(rx, 8'hFF);
    u_master.stop_cond();
    check({power_down, circuit_enable, dac_code}, {2'b10, code_exp});
    check({7'h0, output_live}, 8'h00);
    frame(MY_ADDR, 8'h54, 1'b1, 1'b0);
    code_exp = 6'h15;
    check({power_down, output_live, dac_code}, {2'b00, code_exp});
    n = 0;
    while (output_live !== 1'b1 && n < 3000) begin
      @(negedge ref_clk);
      n++;
    end
    check({7'h0, live_cnt >= 2499 && live_cnt <= 2501}, 8'h01);
    $display("test_shutdown done");
  endtask

  // A mid-run reset stands for a brown-out; the committed code must return to zero.
  task automatic test_brownout();
    check({2'h0, dac_code}, {2'h0, code_exp});
    reset = 1'b1;
    repeat (4) @(negedge ref_clk);
    reset = 1'b0;
    repeat (5) @(negedge ref_clk);
    code_exp = tdr_pkg::CODE_RESET;
    check({power_down, circuit_enable, dac_code}, {2'b01, code_exp});
    check({7'h0, output_live}, 8'h01);
    $display("test_brownout done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence; reset is driven on the falling edge.
  initial begin
    fails = 0;
    check_count = 0;
    code_exp = 6'h00;
    reset = 1'b1;
    repeat (20) @(negedge ref_clk);
    reset = 1'b0;
    repeat (5) @(negedge ref_clk);
    test_reset();
    test_write();
    test_search();
    test_mismatch();
    test_restart();
    test_shutdown();
    test_brownout();
    print_verdict();
  end

  // Watchdog sized well above the expected run of about three quarters of a millisecond.
  initial begin
    #1_800_000;
    fails++;
    print_verdict();
  end
endmodule

`default_nettype wire

/* File: hw/tdr_pin_sync.sv */
// Two-flip-flop synchroniser for a group of asynchronous pin levels.
// Assumes the inputs are slow levels relative to the clock; the first stage feeds only the second.
`timescale 1ns/1ps
`default_nettype none

module tdr_pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  genvar i;

  // One pair of stages per bit; idle bus level is high, so both reset high.
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_q;
      logic meta_d;
      logic sync_q;
      logic sync_d;
      always_comb begin
        meta_d = async_in[i];
        sync_d = meta_q;
      end
      always_ff @(posedge clk) begin
        if (reset) begin
          meta_q <= 1'b1;
          sync_q <= 1'b1;
        end else begin
          meta_q <= meta_d;
          sync_q <= sync_d;
        end
      end
      assign sync_out[i] = sync_q;
    end
  endgenerate

endmodule

`default_nettype wire

/* File: hw/tdr_pkg.sv */
// Shared constants and types for the two-wire DAC code receiver.
// Assumes a 50 MHz system clock; every timing count is derived from it here.
`default_nettype none

package tdr_pkg;

  // System clock period, in nanoseconds.
  localparam int CLK_PERIOD_NS = 20;

  // Width of the committed DAC code and of one bus byte.
  localparam int CODE_W = 6;
  localparam int BYTE_W = 8;

  // Number of steps over the reference span (one step is reference over this figure).
  localparam int CODE_STEPS = 64;

  // Position of the six code bits inside the data byte; the two subbits sit below.
  localparam int CODE_MSB = 7;
  localparam int CODE_LSB = 2;

  // Bit position of the power-down request in the address byte.
  localparam int PD_BIT = 0;

  // Reset values of the committed state.
  localparam logic [5:0] CODE_RESET = 6'h00;
  localparam logic PD_RESET = 1'b0;

  // The four preset slave addresses, left justified with the low bit zero.
  localparam logic [7:0] ADDR_OPT_0 = 8'h60;
  localparam logic [7:0] ADDR_OPT_1 = 8'h62;
  localparam logic [7:0] ADDR_OPT_2 = 8'h64;
  localparam logic [7:0] ADDR_OPT_3 = 8'h66;

  // Highest serial clock rate the receiver is built for, in kilohertz.
  localparam int SCL_MAX_KHZ = 400;

  // Shutdown entry is a longest time, wake-up is a longest time; both round down.
  localparam int PWRDN_ENTRY_NS = 5000;
  localparam int PWRDN_EXIT_NS = 50000;
  localparam int PWRDN_ENTRY_CYCLES = PWRDN_ENTRY_NS / CLK_PERIOD_NS;
  localparam int PWRDN_EXIT_CYCLES = PWRDN_EXIT_NS / CLK_PERIOD_NS;
  localparam int TIMER_W = 12;

  // Protocol states of the receiver.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_DATA,
    ST_DATA_ACK,
    ST_WAIT_STOP,
    ST_IGNORE
  } tdr_state_t;

endpackage

`default_nettype wire

/* File: hw/tdr_receiver.sv */
// Two-wire slave receiver that captures a DAC code and a power-down request.
// Assumes the bus pins are asynchronous to ref_clk and are oversampled here;
// the analog section consumes the committed code and power flags.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Six code bits are straight binary, MSB first, one step is reference over 64.
// - Power-on or brown-out reset clears the committed code to zero.
// - Shutdown disables circuits and zeroes output; entry under 5 us; exit required under 50 us but takes the full 2500 cycles, 50 us, after the flag falls.
// - The device only pulls the data line low, and only for acknowledge.
// - Data is sampled while the clock line is high.
// - Transaction is START, address with power bit, one data byte, STOP.
// - Each byte takes nine clocks; the ninth is the acknowledge slot.
// - The seven address bits are matched against one of four preset addresses.
// - The eighth address bit requests shutdown when one, normal mode when zero.
// - Address is acknowledged either way; immediate STOP or restart changes nothing.
// - Power state and code update only after the second byte fully transfers.
// - After the data acknowledge the new code is applied at STOP.
// - With power-down requested the data line stays released, reading all ones.
// - The general call address and CBUS transfers get no response.
// - Only seven-bit addressing; ten-bit formats get no response.
// - Restart is allowed, but only a STOP right after the data byte commits.
// - The interface works at clock rates up to 400 kHz.
module tdr_receiver #(
  parameter int ADDR_OPTION = 0
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic [5:0] dac_code,
  output logic power_down,
  output logic circuit_enable,
  output logic output_live
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling and bus condition detection.

  localparam int ENTRY_INT = tdr_pkg::PWRDN_ENTRY_CYCLES;

  logic [1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic scl_p_q;
  logic sda_p_q;
  logic scl_rise;
  logic scl_fall;
  logic start_evt;
  logic stop_evt;
  logic [7:0] own_addr;

  // Both pins pass two flops; 50 MHz gives over sixty samples per 400 kHz bit.
  tdr_pin_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk(ref_clk),
    .reset(reset),
    .async_in({scl_in, sda_in}),
    .sync_out(pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // Previous samples for edge and condition detection; reset to the idle-high bus.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // A data change while the clock stays high can only be START or STOP.
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign start_evt = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_evt = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // The preset address is fixed per build; other values fall back to the first option.
  always_comb begin
    case (ADDR_OPTION)
      1: own_addr = tdr_pkg::ADDR_OPT_1;
      2: own_addr = tdr_pkg::ADDR_OPT_2;
      3: own_addr = tdr_pkg::ADDR_OPT_3;
      default: own_addr = tdr_pkg::ADDR_OPT_0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protocol state machine.

  tdr_pkg::tdr_state_t state_q;
  tdr_pkg::tdr_state_t state_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [3:0] bit_cnt_q;
  logic [3:0] bit_cnt_d;
  logic ack_seen_q;
  logic ack_seen_d;
  logic pd_req_q;
  logic pd_req_d;
  logic [5:0] code_buf_q;
  logic [5:0] code_buf_d;
  logic sda_oe_q;
  logic sda_oe_d;
  logic sda_out_q;
  logic commit;
  logic addr_hit;

  // The seven upper bits must equal the preset; general call and ten-bit headers never do.
  assign addr_hit = (shift_q[7:1] == own_addr[7:1]);

  // A STOP while waiting after the data acknowledge is the only commit point.
  assign commit = stop_evt & (state_q == tdr_pkg::ST_WAIT_STOP);

  // Next-state logic; START and STOP override everything so a broken frame cannot hang us.
  always_comb begin
    state_d = state_q;
    shift_d = shift_q;
    bit_cnt_d = bit_cnt_q;
    ack_seen_d = ack_seen_q;
    pd_req_d = pd_req_q;
    code_buf_d = code_buf_q;
    sda_oe_d = sda_oe_q;
    if (start_evt) begin
      // Restart abandons any uncommitted byte and begins a new address.
      state_d = tdr_pkg::ST_ADDR;
      shift_d = 8'h00;
      bit_cnt_d = 4'h0;
      ack_seen_d = 1'b0;
      sda_oe_d = 1'b0;
    end else if (stop_evt) begin
      state_d = tdr_pkg::ST_IDLE;
      bit_cnt_d = 4'h0;
      sda_oe_d = 1'b0;
    end else begin
      case (state_q)
        tdr_pkg::ST_IDLE: begin
          sda_oe_d = 1'b0;
        end
        tdr_pkg::ST_ADDR, tdr_pkg::ST_DATA: begin
          if (scl_rise && bit_cnt_q < 4'h8) begin
            // Sample while the clock is high, MSB first.
            shift_d = {shift_q[6:0], sda_s};
            bit_cnt_d = bit_cnt_q + 4'h1;
          end else if (scl_fall && bit_cnt_q == 4'h8) begin
            bit_cnt_d = 4'h0;
            ack_seen_d = 1'b0;
            if (state_q == tdr_pkg::ST_ADDR) begin
              if (addr_hit) begin
                // Acknowledge the address whatever the power bit says.
                state_d = tdr_pkg::ST_ADDR_ACK;
                sda_oe_d = 1'b1;
                pd_req_d = shift_q[tdr_pkg::PD_BIT];
              end else begin
                state_d = tdr_pkg::ST_IGNORE;
              end
            end else begin
              // In a read-out the master acknowledges, so the line stays released.
              state_d = tdr_pkg::ST_DATA_ACK;
              sda_oe_d = ~pd_req_q;
              code_buf_d = shift_q[tdr_pkg::CODE_MSB:tdr_pkg::CODE_LSB];
            end
          end
        end
        tdr_pkg::ST_ADDR_ACK, tdr_pkg::ST_DATA_ACK: begin
          // Hold the acknowledge through the ninth clock and release on its falling edge.
          if (scl_rise) begin
            ack_seen_d = 1'b1;
          end else if (scl_fall && ack_seen_q) begin
            sda_oe_d = 1'b0;
            ack_seen_d = 1'b0;
            if (state_q == tdr_pkg::ST_ADDR_ACK) begin
              state_d = tdr_pkg::ST_DATA;
            end else begin
              state_d = tdr_pkg::ST_WAIT_STOP;
            end
          end
        end
        tdr_pkg::ST_WAIT_STOP: begin
          // A STOP needs a clock rise first, so only a falling clock proves a third byte.
          if (scl_fall) begin
            state_d = tdr_pkg::ST_IGNORE;
          end
        end
        tdr_pkg::ST_IGNORE: begin
          sda_oe_d = 1'b0;
        end
        default: begin
          state_d = tdr_pkg::ST_IDLE;
          sda_oe_d = 1'b0;
        end
      endcase
    end
  end

  // Registers of the protocol group.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= tdr_pkg::ST_IDLE;
      shift_q <= 8'h00;
      bit_cnt_q <= 4'h0;
      ack_seen_q <= 1'b0;
      pd_req_q <= tdr_pkg::PD_RESET;
      code_buf_q <= tdr_pkg::CODE_RESET;
      sda_oe_q <= 1'b0;
      sda_out_q <= 1'b0;
    end else begin
      state_q <= state_d;
      shift_q <= shift_d;
      bit_cnt_q <= bit_cnt_d;
      ack_seen_q <= ack_seen_d;
      pd_req_q <= pd_req_d;
      code_buf_q <= code_buf_d;
      sda_oe_q <= sda_oe_d;
      sda_out_q <= 1'b0; // Open drain: the only level ever driven is low.
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Committed code, power state and shutdown timing.

  logic [5:0] code_q;
  logic [5:0] code_d;
  logic pd_q;
  logic pd_d;
  logic circuit_q;
  logic circuit_d;
  logic live_q;
  logic live_d;
  logic [11:0] wake_cnt_q;
  logic [11:0] wake_cnt_d;

  // A read-out frame only changes the power mode; the code keeps its last value.
  always_comb begin
    code_d = code_q;
    pd_d = pd_q;
    circuit_d = ~pd_q;
    live_d = live_q;
    wake_cnt_d = wake_cnt_q;
    if (commit) begin
      pd_d = pd_req_q;
      if (!pd_req_q) begin
        code_d = code_buf_q;
      end
    end
    if (pd_q) begin
      // Entry drops the output at once, well inside the entry limit.
      live_d = 1'b0;
      wake_cnt_d = 12'h000;
    end else if (!live_q) begin
      // Wake-up waits out the exit time so the analog path has settled.
      if (wake_cnt_q == 12'(tdr_pkg::PWRDN_EXIT_CYCLES - 1)) begin
        live_d = 1'b1;
      end else begin
        wake_cnt_d = wake_cnt_q + 12'h001;
      end
    end
  end

  // Reset stands for power-on and brown-out: code zero, powered up.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      code_q <= tdr_pkg::CODE_RESET;
      pd_q <= tdr_pkg::PD_RESET;
      circuit_q <= 1'b1;
      live_q <= 1'b1;
      wake_cnt_q <= 12'h000;
    end else begin
      code_q <= code_d;
      pd_q <= pd_d;
      circuit_q <= circuit_d;
      live_q <= live_d;
      wake_cnt_q <= wake_cnt_d;
    end
  end

  assign sda_out = sda_out_q;
  assign sda_oe = sda_oe_q;
  assign dac_code = code_q;
  assign power_down = pd_q;
  assign circuit_enable = circuit_q;
  assign output_live = live_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the driven behaviour.

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // The data line is pulled only inside an acknowledge slot.
  a_ack_only_drive: assert property (
    sda_oe_q |-> (state_q == tdr_pkg::ST_ADDR_ACK || state_q == tdr_pkg::ST_DATA_ACK)
  ) else $error("data line driven outside an acknowledge slot");

  // A read-out data byte is never driven.
  a_read_released: assert property (
    (state_q == tdr_pkg::ST_DATA || state_q == tdr_pkg::ST_DATA_ACK) && pd_req_q |-> !sda_oe_q
  ) else $error("data line driven during read-out");

  // The code changes only one cycle after a STOP in the wait state.
  a_code_at_stop: assert property (
    $changed(code_q) |-> $past(commit) && !$past(pd_req_q)
  ) else $error("code changed without a committing stop");

  // The power state changes only at a committing STOP.
  a_pd_at_stop: assert property (
    $changed(pd_q) |-> $past(commit) && (pd_q == $past(pd_req_q))
  ) else $error("power state changed without a committing stop");

  // The shift register moves only on a clock rise or a START.
  a_sample_high: assert property (
    $changed(shift_q) |-> $past(scl_rise) || $past(start_evt)
  ) else $error("data sampled outside a clock rise");

  // A full address that does not match leads to the ignore state, not an acknowledge.
  a_mismatch_nack: assert property (
    (state_q == tdr_pkg::ST_ADDR) && (bit_cnt_q == 4'h8) && scl_fall && !addr_hit && !start_evt && !stop_evt
    |=> (state_q == tdr_pkg::ST_IGNORE) && !sda_oe_q
  ) else $error("mismatched address not ignored");

  // A matching address is acknowledged on the next cycle.
  a_match_ack: assert property (
    (state_q == tdr_pkg::ST_ADDR) && (bit_cnt_q == 4'h8) && scl_fall && addr_hit && !start_evt && !stop_evt
    |=> (state_q == tdr_pkg::ST_ADDR_ACK) && sda_oe_q
  ) else $error("matching address not acknowledged");

  // Shutdown entry takes the output down within the entry limit.
  a_entry_time: assert property (
    $rose(pd_q) |-> ##[0:ENTRY_INT] !live_q
  ) else $error("shutdown entry too slow");

  // Wake-up completes exactly at the exit count.
  a_exit_time: assert property (
    $rose(live_q) |-> $past(wake_cnt_q) == 12'(tdr_pkg::PWRDN_EXIT_CYCLES - 1)
  ) else $error("wake-up count wrong");

  // Reset leaves the code at zero.
  a_reset_zero: assert property (
    @(posedge ref_clk) disable iff (1'b0) $past(reset) |-> code_q == tdr_pkg::CODE_RESET
  ) else $error("code not zero after reset");

endmodule

`default_nettype wire
